// [bench/remote_terminal_interrupt_logic_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rtil_consts.svh"
module remote_terminal_interrupt_logic_tb_top;
	import rtil_pkg::*;
	logic CLK = 1'b0;
	logic ARST_N = 1'b0;
	logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
	logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
	logic TERM_MSG_DONE = 1'b0, TERM_ERR_BUSY = 1'b0, OTHER_IRQ = 1'b0;
	logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA, rv;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rr;
	rtil_word_t TERM_EVENT = 16'h0000, LOG_IDENT, lw;
	logic LOG_WRITE, IRQ_N, logged, irq;
	int err_count = 0, compares = 0, cyc = 0;
	rtil_top #(.TICK_DIV(2)) dut_u (.*);
	rtil_host host_u (.*);
	// Clock of 50 ns and a cycle ceiling against hangs.
	always #25 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			report_and_stop;
		end
	end
	task automatic report_and_stop;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rdc(input string nm, input logic [15:0] i, input logic [31:0] exp);
		host_u.rd(i, rv, rr);
		chk(nm, rv, exp);
	endtask
	// Pulse events, then a completion; record any log write and the request level.
	task automatic msg(input rtil_word_t b, input logic e);
		@(posedge CLK);
		TERM_EVENT <= b;
		TERM_ERR_BUSY <= e;
		@(posedge CLK);
		TERM_EVENT <= 16'h0000;
		TERM_MSG_DONE <= 1'b1;
		@(posedge CLK);
		TERM_MSG_DONE <= 1'b0;
		logged = 1'b0;
		repeat (6) begin
			@(negedge CLK);
			if (LOG_WRITE === 1'b1) begin
				logged = 1'b1;
				lw = LOG_IDENT;
			end
		end
		@(posedge CLK);
		TERM_ERR_BUSY <= 1'b0;
		@(negedge CLK);
		irq = IRQ_N;
	endtask
	// Main sequence of register and event scenarios.
	initial begin
		repeat (2) @(posedge CLK);
		ARST_N <= 1'b1;
		rdc("pend", `RTIL_IDX_PEND, 32'h0);
		rdc("en", `RTIL_IDX_EN, 32'h0);
		rdc("oe", `RTIL_IDX_OE, 32'h0);
		chk("resp", rr, `RTIL_RESP_OKAY);
		rdc("bad", 16'h0003, 32'h0);
		chk("resp", rr, `RTIL_RESP_SLVERR);
		host_u.wr(16'h0003, 16'h0000);
		chk("bresp", host_u.last_bresp, `RTIL_RESP_SLVERR);
		host_u.wr(`RTIL_IDX_EN, 16'h0003);
		chk("bresp", host_u.last_bresp, `RTIL_RESP_OKAY);
		host_u.wr(`RTIL_IDX_OE, 16'h0001);
		msg(16'h0004, 1'b0);
		chk("log", logged, 1'b0);
		host_u.wr(`RTIL_IDX_EN, 16'h0007);
		rdc("pend", `RTIL_IDX_PEND, 32'h0);
		msg(16'h0002, 1'b0);
		chk("log", logged, 1'b1);
		chk("irq", irq, 1'b1);
		msg(16'h0004, 1'b0);
		chk("ident", lw, 16'h0004);
		rdc("pend", `RTIL_IDX_PEND, 32'h6);
		rdc("pend", `RTIL_IDX_PEND, 32'h0);
		host_u.wr(`RTIL_IDX_XCFG, 16'h0004);
		msg(16'h0001, 1'b0);
		chk("irq", irq, 1'b0);
		chk("ident", lw, 16'h0201);
		rdc("hwpend", `RTIL_IDX_HWPEND, 32'h2);
		rdc("pend", `RTIL_IDX_PEND, 32'h1);
		@(negedge CLK);
		chk("irq", IRQ_N, 1'b1);
		host_u.wr(`RTIL_IDX_XCFG, 16'h0001);
		msg(16'h0001, 1'b1);
		chk("irq", irq, 1'b1);
		rdc("pend", `RTIL_IDX_PEND, 32'h1);
		OTHER_IRQ <= 1'b1;
		@(negedge CLK);
		chk("irq", IRQ_N, 1'b0);
		@(posedge CLK);
		OTHER_IRQ <= 1'b0;
		host_u.wr(`RTIL_IDX_HWPEND, 16'hFFFF);
		host_u.wr(`RTIL_IDX_HWEN, 16'h0010);
		host_u.wr(`RTIL_IDX_UT1, 16'h1234);
		host_u.wr(`RTIL_IDX_UT2, 16'h1234);
		host_u.wr(`RTIL_IDX_TT1, 16'h0000);
		host_u.wr(`RTIL_IDX_TT2, 16'h0000);
		rdc("hwpend", `RTIL_IDX_HWPEND, 32'h10);
		host_u.wr(`RTIL_IDX_HWEN, 16'h0030);
		host_u.wr(`RTIL_IDX_TT2, 16'h0000);
		rdc("hwpend", `RTIL_IDX_HWPEND, 32'h30);
		host_u.wr(`RTIL_IDX_HWOE, 16'h0010);
		@(negedge CLK);
		chk("irq", IRQ_N, 1'b0);
		host_u.wr(`RTIL_IDX_HWPEND, 16'h0030);
		@(negedge CLK);
		chk("irq", IRQ_N, 1'b1);
		report_and_stop;
	end
endmodule
`default_nettype wire

// [bench/rtil_host.sv]
`timescale 1ns/1ps
`default_nettype none
module rtil_host (
	input wire logic CLK,
	output logic [31:0] S_AXI_AWADDR,
	output logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	output logic [31:0] S_AXI_WDATA,
	output logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BREADY,
	output logic [31:0] S_AXI_ARADDR,
	output logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	output logic S_AXI_RREADY
);
	// Response code of the most recent write.
	logic [1:0] last_bresp;
	// The host starts with an idle bus.
	initial begin
		last_bresp = 2'h0;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
		{S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR} = 96'h0;
	end
	// One write; address and data are released as each is taken.
	// Handshakes are judged on values settled before the edge at which they count.
	task automatic wr(input logic [15:0] i, input logic [15:0] d);
		logic aw_hs;
		logic w_hs;
		logic b_hs;
		@(posedge CLK);
		S_AXI_AWADDR <= {14'h0, i, 2'h0};
		S_AXI_WDATA <= {16'h0, d};
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
		do begin
			@(negedge CLK);
			aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
			w_hs = S_AXI_WVALID && S_AXI_WREADY;
			b_hs = S_AXI_BVALID && S_AXI_BREADY;
			if (b_hs) last_bresp = S_AXI_BRESP;
			@(posedge CLK);
			if (aw_hs) S_AXI_AWVALID <= 1'b0;
			if (w_hs) S_AXI_WVALID <= 1'b0;
		end while (!b_hs);
		S_AXI_BREADY <= 1'b0;
	endtask
	// One read; the host identifies sources by reading registers.
	task automatic rd(input logic [15:0] i, output logic [31:0] d, output logic [1:0] r);
		logic ar_hs;
		logic r_hs;
		@(posedge CLK);
		S_AXI_ARADDR <= {14'h0, i, 2'h0};
		{S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
		do begin
			@(negedge CLK);
			ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
			r_hs = S_AXI_RVALID && S_AXI_RREADY;
			d = S_AXI_RDATA;
			r = S_AXI_RRESP;
			@(posedge CLK);
			if (ar_hs) S_AXI_ARVALID <= 1'b0;
		end while (!r_hs);
		S_AXI_RREADY <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [bench/rtil_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module rtil_chk #(
	parameter int TICK_DIV = 40
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic TERM_MSG_DONE,
	input wire logic OTHER_IRQ,
	input wire logic LOG_WRITE,
	input wire logic IRQ_N
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	// The write answer stands at the second edge after address and data are taken together.
	a_b_late: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
		&& S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("write answer late");
	// The read answer stands at the edge after the address is taken, until accepted.
	a_r_late: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write answer dropped");
	a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
		&& $stable(S_AXI_RDATA)) else $error("read answer dropped");
	a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("second read accepted");
	// A log write is a single pulse three cycles after message completion.
	a_log_pulse: assert property (LOG_WRITE |=> !LOG_WRITE)
		else $error("log pulse too long");
	a_log_cause: assert property (LOG_WRITE |-> $past(TERM_MSG_DONE, 3))
		else $error("log write without completion");
	a_other_irq: assert property (OTHER_IRQ |-> !IRQ_N)
		else $error("shared request not asserted");
	// Main scenarios that the bench should reach.
	c_log: cover property (LOG_WRITE);
	c_irq: cover property (!IRQ_N && !OTHER_IRQ);
	c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule
bind rtil_top rtil_chk #(.TICK_DIV(TICK_DIV)) chk_u (.*);
`default_nettype wire

// [logic/rtil_consts.svh]
`ifndef RTIL_CONSTS_SVH
`define RTIL_CONSTS_SVH
// Register word indices; byte address is four times the index.
`define RTIL_IDX_PEND 16'h0009
`define RTIL_IDX_EN 16'h0012
`define RTIL_IDX_OE 16'h0016
`define RTIL_IDX_HWEN 16'h000F
`define RTIL_IDX_HWPEND 16'h0040
`define RTIL_IDX_TT1 16'h0049
`define RTIL_IDX_UT1 16'h004A
`define RTIL_IDX_TT2 16'h004B
`define RTIL_IDX_UT2 16'h004C
`define RTIL_IDX_XCFG 16'h004D
`define RTIL_IDX_HWOE 16'h0041
// Hardware pending and enable bit positions.
`define RTIL_BIT_TERM_SUM 1
`define RTIL_BIT_TTM1 4
`define RTIL_BIT_TTM2 5
// Extended configuration bit positions.
`define RTIL_BIT_SUPPRESS 0
`define RTIL_BIT_LOGBUSY 2
// Reserved pending bit and log word busy bit.
`define RTIL_BIT_RSVD 9
`define RTIL_RESET_16 16'h0000
`define RTIL_RESP_OKAY 2'b00
`define RTIL_RESP_SLVERR 2'b10
`endif

// [logic/rtil_pkg.sv]
package rtil_pkg;
	typedef logic [15:0] rtil_word_t;
	typedef logic [1:0] rtil_resp_t;
endpackage

// [logic/rtil_top.sv]
// Function
// - Terminal one match raises count-match interrupt.
// - Terminal two match raises count-match interrupt.
// - Match interrupts need hardware enable bits.
// - Disabled terminal events are fully ignored.
// - Enabling never recognises earlier events.
// - Enabled events OR into pending register.
// - Every enabled event updates the log.
// - Enabled events set terminal summary bit one.
// - Output-enabled events assert request at completion.
// - Low priority events update pending, no request.
// - Reading pending returns then clears it.
// - Request is OR of all enabled sources.
// - Suppress bit blocks request on error/busy.
// - Log word mirrors pending pattern.
// - Pending bit nine reads zero; log carries busy.
// - Same bit means same event everywhere.
// - Time tag counters are free-running sixteen bits.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rtil_consts.svh"
module rtil_top #(
	parameter int TICK_DIV = 40
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire rtil_pkg::rtil_word_t TERM_EVENT,
	input wire logic TERM_MSG_DONE,
	input wire logic TERM_ERR_BUSY,
	input wire logic OTHER_IRQ,
	output logic LOG_WRITE,
	output rtil_pkg::rtil_word_t LOG_IDENT,
	output logic IRQ_N
);
	import rtil_pkg::*;
	typedef struct packed {
		logic [1:0] ev_sync1;
		logic [1:0] ev_sync2;
		logic [15:0] ev_raw;
		logic [15:0] ev_bits;
		logic [15:0] en;
		logic [15:0] oe;
		logic [15:0] pend;
		logic [15:0] hw_en;
		logic [15:0] hw_oe;
		logic [15:0] hw_pend;
		logic [15:0] ut1;
		logic [15:0] ut2;
		logic [15:0] xcfg;
		logic [15:0] msg_acc;
		logic msg_hi;
		logic irq;
		logic log_wr;
		logic [15:0] log_id;
		logic [31:0] wa;
		logic wa_ok;
		logic [31:0] wd;
		logic wd_ok;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] div;
		logic tick;
		logic [1:0] tt_load;
	} rtil_state_t;
	rtil_state_t s_q;
	rtil_state_t s_d;
	logic [15:0] tt1;
	logic [15:0] tt2;
	logic m1;
	logic m2;
	logic [15:0] ev_now;
	logic done_now;
	logic errbusy_now;
	// Time tag counters for both terminals.
	rtil_ttcnt u_tt1 (
		.clk(CLK),
		.arst_n(ARST_N),
		.tick(s_q.tick),
		.utility(s_q.ut1),
		.load(s_q.tt_load[0]),
		.count(tt1),
		.match(m1)
	);
	rtil_ttcnt u_tt2 (
		.clk(CLK),
		.arst_n(ARST_N),
		.tick(s_q.tick),
		.utility(s_q.ut2),
		.load(s_q.tt_load[1]),
		.count(tt2),
		.match(m2)
	);
	// Event pins come from the terminal engine's domain; both stages live in the state struct.
	// Only the second stage is read, so a metastable first stage never reaches the pending logic.
	assign ev_now = s_q.ev_bits;
	assign done_now = s_q.ev_sync2[0];
	assign errbusy_now = s_q.ev_sync2[1];
	// Register lookup for reads, by word index.
	function automatic logic [32:0] rd_word(input rtil_state_t s, input logic [15:0] i,
			input logic [15:0] c1, input logic [15:0] c2);
		logic [32:0] r;
		r = {1'b1, 32'h0000_0000};
		unique case (i)
			`RTIL_IDX_PEND: r[15:0] = s.pend;
			`RTIL_IDX_EN: r[15:0] = s.en;
			`RTIL_IDX_OE: r[15:0] = s.oe;
			`RTIL_IDX_HWEN: r[15:0] = s.hw_en;
			`RTIL_IDX_HWOE: r[15:0] = s.hw_oe;
			`RTIL_IDX_HWPEND: r[15:0] = s.hw_pend;
			`RTIL_IDX_TT1: r[15:0] = c1;
			`RTIL_IDX_UT1: r[15:0] = s.ut1;
			`RTIL_IDX_TT2: r[15:0] = c2;
			`RTIL_IDX_UT2: r[15:0] = s.ut2;
			`RTIL_IDX_XCFG: r[15:0] = s.xcfg;
			default: r[32] = 1'b0;
		endcase
		return r;
	endfunction
	// Next-state logic: bus slave, event capture, pending, log and request.
	always_comb begin
		logic [15:0] hit;
		logic [15:0] widx;
		logic [15:0] ridx;
		logic [32:0] rw;
		logic [15:0] wv;
		logic [15:0] hw_set;
		logic rd_pend;
		logic hw_wr_clr;
		hit = '0;
		widx = '0;
		ridx = '0;
		rw = '0;
		wv = '0;
		hw_set = '0;
		rd_pend = 1'b0;
		hw_wr_clr = 1'b0;
		s_d = s_q;
		// Two-stage synchronisers for the event, completion and error or busy pins.
		s_d.ev_raw = TERM_EVENT;
		s_d.ev_bits = s_q.ev_raw;
		s_d.ev_sync1 = {TERM_ERR_BUSY, TERM_MSG_DONE};
		s_d.ev_sync2 = s_q.ev_sync1;
		s_d.log_wr = 1'b0;
		s_d.tt_load = 2'b00;
		// Tick divider for the time tag rate.
		s_d.tick = 1'b0;
		if (s_q.div == 16'(TICK_DIV - 1)) begin
			s_d.div = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.div = s_q.div + 16'h0001;
		end
		// Write channel capture, address and data in either order.
		if (S_AXI_AWVALID && !s_q.wa_ok) begin
			s_d.wa = S_AXI_AWADDR;
			s_d.wa_ok = 1'b1;
		end
		if (S_AXI_WVALID && !s_q.wd_ok) begin
			s_d.wd = S_AXI_WDATA;
			s_d.wd_ok = 1'b1;
		end
		if (s_q.bvalid && S_AXI_BREADY) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.wa_ok && s_q.wd_ok && !s_q.bvalid) begin
			widx = s_q.wa[17:2];
			wv = s_q.wd[15:0];
			s_d.wa_ok = 1'b0;
			s_d.wd_ok = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = `RTIL_RESP_OKAY;
			unique case (widx)
				`RTIL_IDX_EN: s_d.en = wv;
				`RTIL_IDX_OE: s_d.oe = wv;
				`RTIL_IDX_HWEN: s_d.hw_en = wv;
				`RTIL_IDX_HWOE: s_d.hw_oe = wv;
				`RTIL_IDX_HWPEND: hw_wr_clr = 1'b1;
				`RTIL_IDX_UT1: s_d.ut1 = wv;
				`RTIL_IDX_UT2: s_d.ut2 = wv;
				`RTIL_IDX_XCFG: s_d.xcfg = wv;
				`RTIL_IDX_TT1: s_d.tt_load[0] = 1'b1;
				`RTIL_IDX_TT2: s_d.tt_load[1] = 1'b1;
				`RTIL_IDX_PEND: s_d.bresp = `RTIL_RESP_OKAY;
				default: s_d.bresp = `RTIL_RESP_SLVERR;
			endcase
		end
		// Read channel; pending read also clears the register.
		if (s_q.rvalid && S_AXI_RREADY) begin
			s_d.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && !s_q.rvalid) begin
			ridx = S_AXI_ARADDR[17:2];
			rw = rd_word(s_q, ridx, tt1, tt2);
			s_d.rvalid = 1'b1;
			s_d.rdata = rw[31:0];
			s_d.rresp = rw[32] ? `RTIL_RESP_OKAY : `RTIL_RESP_SLVERR;
			rd_pend = (ridx == `RTIL_IDX_PEND);
		end
		if (rd_pend) begin
			s_d.pend = '0;
		end
		if (hw_wr_clr) begin
			s_d.hw_pend = s_q.hw_pend & ~wv;
		end
		// Only events seen while enabled are gathered; no history is kept.
		hit = ev_now & s_q.en;
		hit[`RTIL_BIT_RSVD] = 1'b0;
		s_d.pend = s_d.pend | hit;
		s_d.msg_acc = s_q.msg_acc | hit;
		if (|hit) begin
			s_d.msg_hi = s_q.msg_hi | (|(hit & s_q.oe));
		end
		// At message completion the log is written and the request decided.
		if (done_now && |s_d.msg_acc) begin
			s_d.log_wr = 1'b1;
			s_d.log_id = s_d.msg_acc;
			s_d.log_id[`RTIL_BIT_RSVD] = s_q.xcfg[`RTIL_BIT_LOGBUSY];
			// The request is decided before the accumulators are emptied for the next message.
			if (s_d.msg_hi && !(s_q.xcfg[`RTIL_BIT_SUPPRESS] && errbusy_now)) begin
				s_d.irq = 1'b1;
			end
			s_d.msg_acc = '0;
			s_d.msg_hi = 1'b0;
		end
		if (|hit) begin
			hw_set[`RTIL_BIT_TERM_SUM] = 1'b1;
		end
		hw_set[`RTIL_BIT_TTM1] = m1 & s_q.hw_en[`RTIL_BIT_TTM1];
		hw_set[`RTIL_BIT_TTM2] = m2 & s_q.hw_en[`RTIL_BIT_TTM2];
		s_d.hw_pend = s_d.hw_pend | hw_set;
		// Request drops once the whole pending register is zero, low-priority bits included.
		if (s_d.pend == '0) begin
			s_d.irq = 1'b0;
		end
	end
	// State register.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	// Bus handshakes and register-driven outputs.
	assign S_AXI_AWREADY = !s_q.wa_ok;
	assign S_AXI_WREADY = !s_q.wd_ok;
	assign S_AXI_BVALID = s_q.bvalid;
	assign S_AXI_BRESP = s_q.bresp;
	assign S_AXI_ARREADY = !s_q.rvalid;
	assign S_AXI_RVALID = s_q.rvalid;
	assign S_AXI_RDATA = s_q.rdata;
	assign S_AXI_RRESP = s_q.rresp;
	assign LOG_WRITE = s_q.log_wr;
	assign LOG_IDENT = s_q.log_id;
	// One shared active-low request line.
	assign IRQ_N = !(s_q.irq || |(s_q.hw_pend & s_q.hw_oe) || OTHER_IRQ);
endmodule
`default_nettype wire

// [logic/rtil_ttcnt.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rtil_consts.svh"
module rtil_ttcnt (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic tick,
	input wire logic [15:0] utility,
	input wire logic load,
	output logic [15:0] count,
	output logic match
);
	import rtil_pkg::*;
	typedef struct packed {
		logic [15:0] cnt;
		logic match;
	} rtil_tt_state_t;
	rtil_tt_state_t s_q;
	rtil_tt_state_t s_d;
	// Free-running count advances on each tick; match pulses when it lands on the utility value.
	always_comb begin
		s_d = s_q;
		if (load) begin
			s_d.cnt = utility;
		end else if (tick) begin
			s_d.cnt = s_q.cnt + 16'h0001;
		end
		// A fresh count equal to the utility word is a match, whether counted up or loaded.
		s_d.match = (load || tick) && (s_d.cnt == utility);
	end
	// State register.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign count = s_q.cnt;
	assign match = s_q.match;
endmodule
`default_nettype wire
